// file: design/npc_params.svh
// Constants of the numeric coprocessor host port
// How it works
// - Cycles without both selects active are ignored entirely.
// - Selected, command 00, write strobe: data word taken as opcode.
// - Selected, command 00, read strobe: control or status word driven.
// - Selected, command 01, read strobe: operand word driven from buffer.
// - Selected, command 01, write strobe: operand word taken into buffer.
// - Selected, command 10, write strobe: exception pointer stored.
// - Only three host I/O addresses map to select and command pins.
// - Busy rises as soon as an opcode write is recognised.
// - Transfer request is raised only when operand words can move.
// - An exception detected while busy raises the error output.
// - Strobes and command bits are sampled when the cycle is selected.
// - Busy rises after the leading edge of the opcode strobe.
// - Write data taken at strobe trailing edge; read data loaded at leading edge.
// - Operand acknowledge makes the device drop its transfer request.
// - Six administrative opcodes run in the control unit alone.
// - All host strobes and selects are synchronised before use.
// - Strap high uses clock directly; strap low divides by two.
// - Operand path toward the arithmetic unit is 84 bits wide.
// - Over five transfers: request drops after three, then every four.
// - Error mirrors the summary bit and changes only while busy.
// - No opcode is accepted during 25 clocks after reset.
// - During reset busy and error high, request low, bus released.
`ifndef NPC_PARAMS_SVH
`define NPC_PARAMS_SVH
`define NPC_ADDR_OPCODE 16'h00F8
`define NPC_ADDR_DATA 16'h00FA
`define NPC_ADDR_EXCPTR 16'h00FC
`define NPC_ADDR_RESERVED 16'h00FE
`define NPC_CMD_OPCODE 2'h0
`define NPC_CMD_DATA 2'h1
`define NPC_CMD_EXCPTR 2'h2
`define NPC_WARMUP_CLKS 25
`define NPC_RESET_MIN_CLKS 4
`define NPC_ERR_SUM_BIT 7
`define NPC_CTRL_RESET 16'h0000
`define NPC_BURST_LIMIT 6'h05
`define NPC_BURST_FIRST 3'h3
`define NPC_BURST_NEXT 3'h4
`define NPC_SIG_W 68
`define NPC_EXP_W 15
`endif

// file: design/npc_pkg.sv
// Types shared by the coprocessor host port
`include "npc_params.svh"
package npc_pkg;
	typedef enum logic [2:0] {
		NPC_CYC_NONE = 3'b000,
		NPC_CYC_OPCODE = 3'b001,
		NPC_CYC_STAT_RD = 3'b010,
		NPC_CYC_DATA_RD = 3'b011,
		NPC_CYC_DATA_WR = 3'b100,
		NPC_CYC_EXCPTR = 3'b101,
		NPC_CYC_RSVD = 3'b110
	} npc_cycle_e;

	typedef enum logic [1:0] {
		NPC_ST_WARMUP = 2'b00,
		NPC_ST_IDLE = 2'b01,
		NPC_ST_EXEC = 2'b10
	} npc_state_e;

	typedef struct packed {
		logic sel_a_n;
		logic sel_b;
		logic cmd_high;
		logic cmd_low;
		logic rd_n;
		logic wr_n;
		logic ack_n;
		logic [15:0] data;
	} npc_pins_s;

	typedef struct packed {
		logic sign;
		logic [`NPC_EXP_W-1:0] exponent;
		logic [`NPC_SIG_W-1:0] significand;
	} npc_fp_word_s;
endpackage : npc_pkg

// file: design/npc_sync2.sv
// Two-flop synchroniser with a chosen reset value
`timescale 1ns/1ns
module npc_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic clk_in, // Clock
	input wire logic rst_n_in, // Reset, active low
	input wire logic [W-1:0] d_in, // Asynchronous input
	output logic [W-1:0] q_out // Synchronised output
);
	logic [W-1:0] meta;

	generate
		if (W < 1)
		begin : g_bad
			$error("npc_sync2 width must be at least one");
		end
	endgenerate

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta <= RESET_VAL;
			q_out <= RESET_VAL;
		end
		else
		begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule : npc_sync2

// file: design/npc_host_port.sv
// Host bus tracking and CPU synchronisation of the numeric coprocessor
`timescale 1ns/1ns
`include "npc_params.svh"
module npc_host_port #(
	parameter int WARMUP_CLKS = `NPC_WARMUP_CLKS,
	// Administrative opcode patterns; the values are arbitrary
	parameter logic [15:0] OP_INIT = 16'h0001,
	parameter logic [15:0] OP_CLEX = 16'h0002,
	parameter logic [15:0] OP_STSW = 16'h0003,
	parameter logic [15:0] OP_STCW = 16'h0004,
	parameter logic [15:0] OP_SETPM = 16'h0005,
	parameter logic [15:0] OP_RSTPM = 16'h0006
) (
	input wire logic clk_in, // Device clock, 10 MHz
	input wire logic resetn_in, // Reset, active low
	input wire logic clock_divide_strap_in, // 1 direct, 0 divide by two
	input wire logic coproc_select_a_n_in, // Select a, active low
	input wire logic coproc_select_b_in, // Select b, active high
	input wire logic command_bit_low_in, // Command bit 0
	input wire logic command_bit_high_in, // Command bit 1
	input wire logic coproc_read_strobe_n_in, // Read strobe, active low
	input wire logic coproc_write_strobe_n_in, // Write strobe, active low
	input wire logic operand_transfer_ack_n_in, // Acknowledge, active low
	input wire logic [15:0] data_in, // Data pins, input side
	output logic [15:0] data_out, // Data pins, output side
	output logic data_oe_out, // Data pins driven
	output logic busy_out, // Executing, active high
	output logic error_out, // Unmasked exception, active high
	output logic operand_transfer_request_out, // Ready for operand
	output logic [15:0] opcode_out, // Opcode for the sequencer
	output logic opcode_valid_out, // Opcode pulse
	input wire logic core_done_in, // Sequencer finished, level
	input wire logic core_exception_in, // Exception detected
	input wire logic [15:0] core_status_in, // Status from the core
	input wire logic core_xfer_start_in, // Operand phase start pulse
	input wire logic [5:0] core_xfer_count_in, // Operand words to move
	input wire logic [15:0] core_read_word_in, // Next word for host
	output logic [15:0] operand_word_out, // Word written by host
	output logic operand_valid_out, // Operand word pulse
	output npc_pkg::npc_fp_word_s fpu_operand_out, // Wide operand
	output logic [15:0] exc_ptr_out, // Exception pointer word
	output logic exc_ptr_valid_out, // Exception pointer pulse
	output logic [15:0] control_word_out, // Control word
	output logic protected_mode_out // Protected mode flag
);
	localparam npc_pkg::npc_pins_s PINS_IDLE = '{sel_a_n: 1'b1,
		sel_b: 1'b0, cmd_high: 1'b0, cmd_low: 1'b0, rd_n: 1'b1,
		wr_n: 1'b1, ack_n: 1'b1, data: 16'h0000};

	generate
		if (WARMUP_CLKS < 1 || WARMUP_CLKS > 255)
		begin : g_bad
			$error("WARMUP_CLKS must lie in 1 to 255");
		end
	endgenerate

	//------------------------------------------------------------
	// Reset release and clocking
	//------------------------------------------------------------
	logic rst_meta;
	logic rst_n;
	logic rst_done;
	logic strap_sync;
	logic strap_q;
	logic tick_div;
	logic tick;

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	npc_sync2 #(.W(1), .RESET_VAL(1'b0)) u_strap (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.d_in(clock_divide_strap_in),
		.q_out(strap_sync)
	);

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_done <= 1'b0;
			strap_q <= 1'b0;
			tick_div <= 1'b0;
		end
		else
		begin
			rst_done <= 1'b1;
			// Static strap, resampled so the synchroniser has settled
			strap_q <= strap_sync;
			tick_div <= ~tick_div;
		end
	end

	assign tick = strap_q | tick_div;

	//------------------------------------------------------------
	// Pin synchronisation and cycle classification
	//------------------------------------------------------------
	npc_pkg::npc_pins_s pins_raw;
	npc_pkg::npc_pins_s p;
	npc_pkg::npc_cycle_e cyc;
	npc_pkg::npc_cycle_e next_cyc;
	npc_pkg::npc_state_e state;
	logic selected;
	logic rd_act;
	logic wr_act;
	logic ack_act;
	logic lead;
	logic trail;
	logic [15:0] data_hold;

	assign pins_raw = '{sel_a_n: coproc_select_a_n_in,
		sel_b: coproc_select_b_in, cmd_high: command_bit_high_in,
		cmd_low: command_bit_low_in, rd_n: coproc_read_strobe_n_in,
		wr_n: coproc_write_strobe_n_in,
		ack_n: operand_transfer_ack_n_in, data: data_in};

	npc_sync2 #(.W($bits(npc_pkg::npc_pins_s)),
		.RESET_VAL(PINS_IDLE)) u_pins (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.d_in(pins_raw),
		.q_out(p)
	);

	assign selected = !p.sel_a_n && p.sel_b;
	assign rd_act = !p.rd_n;
	assign wr_act = !p.wr_n;
	assign ack_act = !p.ack_n;
	assign lead = (cyc == npc_pkg::NPC_CYC_NONE) && selected &&
		(rd_act || wr_act);
	assign trail = (cyc != npc_pkg::NPC_CYC_NONE) && !rd_act && !wr_act;

	always_comb
	begin
		next_cyc = npc_pkg::NPC_CYC_RSVD;
		case ({p.cmd_high, p.cmd_low})
			`NPC_CMD_OPCODE:
				if (wr_act && !rd_act)
					next_cyc = (state == npc_pkg::NPC_ST_WARMUP) ?
						npc_pkg::NPC_CYC_RSVD :
						npc_pkg::NPC_CYC_OPCODE;
				else if (rd_act && !wr_act)
					next_cyc = npc_pkg::NPC_CYC_STAT_RD;
			`NPC_CMD_DATA:
				if (rd_act && !wr_act)
					next_cyc = npc_pkg::NPC_CYC_DATA_RD;
				else if (wr_act && !rd_act)
					next_cyc = npc_pkg::NPC_CYC_DATA_WR;
			`NPC_CMD_EXCPTR:
				if (wr_act && !rd_act)
					next_cyc = npc_pkg::NPC_CYC_EXCPTR;
			default:
				next_cyc = npc_pkg::NPC_CYC_RSVD;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			cyc <= npc_pkg::NPC_CYC_NONE;
		else if (lead)
			cyc <= next_cyc;
		else if (trail)
			cyc <= npc_pkg::NPC_CYC_NONE;
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			data_hold <= 16'h0000;
		else if (wr_act)
			data_hold <= p.data;
	end

	//------------------------------------------------------------
	// Control unit: state, administrative opcodes, error summary
	//------------------------------------------------------------
	logic [7:0] wu_cnt;
	logic [5:0] xfer_left;
	logic is_admin;
	logic err_sum;
	logic sel_ctrl;
	logic [15:0] status_word;
	logic op_trail;

	assign is_admin = (data_hold == OP_INIT) || (data_hold == OP_CLEX) ||
		(data_hold == OP_STSW) || (data_hold == OP_STCW) ||
		(data_hold == OP_SETPM) || (data_hold == OP_RSTPM);
	assign op_trail = trail && (cyc == npc_pkg::NPC_CYC_OPCODE);

	always_comb
	begin
		status_word = core_status_in;
		status_word[`NPC_ERR_SUM_BIT] = err_sum;
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= npc_pkg::NPC_ST_WARMUP;
			wu_cnt <= 8'h00;
		end
		else
			case (state)
				npc_pkg::NPC_ST_WARMUP:
					if (tick)
					begin
						if (wu_cnt == 8'(WARMUP_CLKS - 1))
							state <= npc_pkg::NPC_ST_IDLE;
						wu_cnt <= wu_cnt + 8'h01;
					end
				npc_pkg::NPC_ST_IDLE:
					if (lead && next_cyc == npc_pkg::NPC_CYC_OPCODE)
						state <= npc_pkg::NPC_ST_EXEC;
				npc_pkg::NPC_ST_EXEC:
					if (op_trail && is_admin)
						state <= npc_pkg::NPC_ST_IDLE;
					else if (!op_trail && cyc == npc_pkg::NPC_CYC_NONE &&
						core_done_in && xfer_left == 6'h00)
						state <= npc_pkg::NPC_ST_IDLE;
				default:
					state <= npc_pkg::NPC_ST_IDLE;
			endcase
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			err_sum <= 1'b0;
			sel_ctrl <= 1'b0;
			control_word_out <= `NPC_CTRL_RESET;
			protected_mode_out <= 1'b0;
		end
		else if (state == npc_pkg::NPC_ST_EXEC)
		begin
			if (op_trail)
				case (data_hold)
					OP_INIT:
					begin
						err_sum <= 1'b0;
						sel_ctrl <= 1'b0;
						control_word_out <= `NPC_CTRL_RESET;
						protected_mode_out <= 1'b0;
					end
					OP_CLEX: err_sum <= 1'b0;
					OP_STSW: sel_ctrl <= 1'b0;
					OP_STCW: sel_ctrl <= 1'b1;
					OP_SETPM: protected_mode_out <= 1'b1;
					OP_RSTPM: protected_mode_out <= 1'b0;
					default: sel_ctrl <= sel_ctrl;
				endcase
			if (core_exception_in)
				err_sum <= 1'b1;
		end
	end

	assign busy_out = (state == npc_pkg::NPC_ST_EXEC) || !rst_done;
	assign error_out = err_sum || !rst_done;

	//------------------------------------------------------------
	// Data movement
	//------------------------------------------------------------
	logic [95:0] opr_shift;

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_out <= 16'h0000;
			data_oe_out <= 1'b0;
		end
		else if (lead)
		begin
			if (next_cyc == npc_pkg::NPC_CYC_STAT_RD)
				data_out <= sel_ctrl ? control_word_out : status_word;
			else if (next_cyc == npc_pkg::NPC_CYC_DATA_RD)
				data_out <= core_read_word_in;
			data_oe_out <= (next_cyc == npc_pkg::NPC_CYC_STAT_RD) ||
				(next_cyc == npc_pkg::NPC_CYC_DATA_RD);
		end
		else if (trail)
			data_oe_out <= 1'b0;
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			opcode_out <= 16'h0000;
			opcode_valid_out <= 1'b0;
			operand_word_out <= 16'h0000;
			operand_valid_out <= 1'b0;
			exc_ptr_out <= 16'h0000;
			exc_ptr_valid_out <= 1'b0;
			opr_shift <= 96'h0;
		end
		else
		begin
			opcode_valid_out <= op_trail && !is_admin;
			operand_valid_out <= trail && cyc == npc_pkg::NPC_CYC_DATA_WR;
			exc_ptr_valid_out <= trail && cyc == npc_pkg::NPC_CYC_EXCPTR;
			if (op_trail)
				opcode_out <= data_hold;
			if (trail && cyc == npc_pkg::NPC_CYC_DATA_WR)
			begin
				operand_word_out <= data_hold;
				opr_shift <= {opr_shift[79:0], data_hold};
			end
			if (trail && cyc == npc_pkg::NPC_CYC_EXCPTR)
				exc_ptr_out <= data_hold;
		end
	end

	assign fpu_operand_out = opr_shift[83:0];

	//------------------------------------------------------------
	// Operand transfer request and bursts
	//------------------------------------------------------------
	logic [2:0] burst_left;
	logic xfer_done;

	assign xfer_done = trail && (cyc == npc_pkg::NPC_CYC_DATA_WR ||
		cyc == npc_pkg::NPC_CYC_DATA_RD) && xfer_left != 6'h00;

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xfer_left <= 6'h00;
			burst_left <= 3'h0;
		end
		else if (core_xfer_start_in && state == npc_pkg::NPC_ST_EXEC)
		begin
			xfer_left <= core_xfer_count_in;
			burst_left <= (core_xfer_count_in > `NPC_BURST_LIMIT) ?
				`NPC_BURST_FIRST : core_xfer_count_in[2:0];
		end
		else if (xfer_done)
		begin
			xfer_left <= xfer_left - 6'h01;
			if (burst_left != 3'h0)
				burst_left <= burst_left - 3'h1;
		end
		else if (ack_act)
			burst_left <= 3'h0;
		else if (tick && burst_left == 3'h0 && xfer_left != 6'h00 &&
			cyc == npc_pkg::NPC_CYC_NONE)
			burst_left <= (xfer_left > {3'h0, `NPC_BURST_NEXT}) ?
				`NPC_BURST_NEXT : xfer_left[2:0];
	end

	assign operand_transfer_request_out = rst_done &&
		burst_left != 3'h0 && !ack_act;

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	a_select_ignore: assert property ((!selected &&
		cyc == npc_pkg::NPC_CYC_NONE) |=> cyc == npc_pkg::NPC_CYC_NONE)
		else $error("unselected cycle was classified");
	a_busy_rise: assert property ((lead && state == npc_pkg::NPC_ST_IDLE &&
		next_cyc == npc_pkg::NPC_CYC_OPCODE) |=> busy_out)
		else $error("busy did not rise on opcode");
	a_opcode_take: assert property ((op_trail && !is_admin) |=>
		opcode_valid_out && opcode_out == $past(data_hold))
		else $error("opcode not taken at trailing edge");
	a_status_read: assert property ((lead &&
		next_cyc == npc_pkg::NPC_CYC_STAT_RD) |=> data_oe_out &&
		data_out == $past(sel_ctrl ? control_word_out : status_word))
		else $error("wrong control or status word driven");
	a_operand_write: assert property ((trail &&
		cyc == npc_pkg::NPC_CYC_DATA_WR) |=> operand_valid_out &&
		operand_word_out == $past(data_hold))
		else $error("operand word not taken");
	a_exc_ptr: assert property ((trail && cyc == npc_pkg::NPC_CYC_EXCPTR)
		|=> exc_ptr_valid_out && exc_ptr_out == $past(data_hold))
		else $error("exception pointer not stored");
	a_bus_release: assert property (data_oe_out |-> (cyc ==
		npc_pkg::NPC_CYC_STAT_RD || cyc == npc_pkg::NPC_CYC_DATA_RD))
		else $error("data bus driven outside a read");
	a_rsvd_quiet: assert property ((cyc == npc_pkg::NPC_CYC_RSVD) |->
		!data_oe_out && !opcode_valid_out && !operand_valid_out)
		else $error("reserved cycle had an effect");
	a_ack_drop: assert property (ack_act |->
		!operand_transfer_request_out)
		else $error("request held during acknowledge");
	a_error_hold: assert property ((state != npc_pkg::NPC_ST_EXEC) |=>
		err_sum == $past(err_sum))
		else $error("error changed while not busy");
	a_burst_first: assert property ((core_xfer_start_in &&
		state == npc_pkg::NPC_ST_EXEC && core_xfer_count_in > 6'h05)
		|=> burst_left == 3'h3)
		else $error("first burst is not three words");
	a_req_before_busy: assert property ($fell(busy_out) |->
		!operand_transfer_request_out && xfer_left == 6'h00)
		else $error("busy fell with transfers pending");
	a_reset_pins: assert property (!rst_done |-> busy_out && error_out &&
		!operand_transfer_request_out && !data_oe_out)
		else $error("outputs wrong during reset");

	c_opcode: cover property (op_trail && !is_admin);
	c_admin: cover property (op_trail && is_admin);
	c_data_read: cover property (lead &&
		next_cyc == npc_pkg::NPC_CYC_DATA_RD);
	c_burst_rearm: cover property (burst_left == 3'h0 &&
		xfer_left != 6'h00 ##1 burst_left != 3'h0);
endmodule : npc_host_port

// file: dv/npc_host_model.sv
// Host CPU model issuing coprocessor bus cycles
`timescale 1ns/1ns
`include "npc_params.svh"
module npc_host_model (
	input wire logic clk_in, // Clock
	input wire logic [15:0] dev_data_in, // Device data output
	input wire logic dev_oe_in, // Device drives the bus
	output npc_pkg::npc_pins_s pins_out, // Host side pins
	output logic [15:0] bus_out // Resolved data bus
);
	logic [15:0] idle_q;
	// ----------------------------------------
	// Bus resolution: a released bus wanders
	// ----------------------------------------
	assign bus_out = dev_oe_in ? dev_data_in :
		(!pins_out.wr_n ? pins_out.data : idle_q);
	always @(posedge clk_in)
	begin
		idle_q <= ~bus_out;
	end
	initial
	begin
		pins_out = '1;
		idle_q = 16'h5A5A;
	end
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task automatic cyc(input logic a_n, input logic b, input logic [1:0] cmd,
		input logic rd_n, input logic wr_n, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge clk_in);
		pins_out.sel_a_n <= a_n;
		pins_out.sel_b <= b;
		{pins_out.cmd_high, pins_out.cmd_low} <= cmd;
		pins_out.rd_n <= rd_n;
		pins_out.wr_n <= wr_n;
		pins_out.data <= d;
		repeat (4) @(posedge clk_in);
		q = bus_out;
		pins_out.rd_n <= 1'b1;
		pins_out.wr_n <= 1'b1;
		pins_out.sel_a_n <= 1'b1;
		pins_out.sel_b <= 1'b1;
		repeat (5 + $urandom_range(0, 2)) @(posedge clk_in);
	endtask : cyc
	task automatic io(input logic [15:0] addr, input logic rd,
		input logic [15:0] d, output logic [15:0] q);
		logic hit;
		hit = addr == `NPC_ADDR_OPCODE || addr == `NPC_ADDR_DATA ||
			addr == `NPC_ADDR_EXCPTR;
		cyc(~hit, 1'b1, addr[2:1], ~rd, rd, d, q);
	endtask : io
	task automatic ack(input logic v);
		@(posedge clk_in);
		pins_out.ack_n <= ~v;
	endtask : ack
endmodule : npc_host_model

// file: dv/testbench.sv
// Self-checking bench for the coprocessor host port
`timescale 1ns/1ns
`include "npc_params.svh"
module testbench;
	localparam logic [15:0] ADM [6] = '{16'h0A01, 16'h0A02, 16'h0A03,
		16'h0A04, 16'h0A05, 16'h0A06};
	localparam logic [15:0] AD = `NPC_ADDR_DATA;
	localparam logic [15:0] AO = `NPC_ADDR_OPCODE;
	logic clk_in, resetn_in, strap, oe, busy, err, req, opv, wv, ev, pm;
	logic c_done, c_exc, c_start;
	logic [5:0] c_cnt;
	logic [15:0] dout, bus, op, wd, ep, ctrl, c_stat, c_rd, q;
	logic [95:0] hist;
	npc_pkg::npc_pins_s pins;
	npc_pkg::npc_fp_word_s fpu;
	int n_errors, cmp_count, n_op, n_w, n_e, n_oe, n_x, last_x, i;
	int seen[$];
	logic [15:0] eq_op[$], eq_w[$], eq_e[$];
	logic req_q;
	npc_host_model host (.clk_in(clk_in), .dev_data_in(dout),
		.dev_oe_in(oe), .pins_out(pins), .bus_out(bus));
	npc_host_port #(.WARMUP_CLKS(3), .OP_INIT(ADM[0]), .OP_CLEX(ADM[1]),
		.OP_STSW(ADM[2]), .OP_STCW(ADM[3]), .OP_SETPM(ADM[4]),
		.OP_RSTPM(ADM[5])) dut (
		.clk_in(clk_in), .resetn_in(resetn_in),
		.clock_divide_strap_in(strap),
		.coproc_select_a_n_in(pins.sel_a_n),
		.coproc_select_b_in(pins.sel_b),
		.command_bit_low_in(pins.cmd_low),
		.command_bit_high_in(pins.cmd_high),
		.coproc_read_strobe_n_in(pins.rd_n),
		.coproc_write_strobe_n_in(pins.wr_n),
		.operand_transfer_ack_n_in(pins.ack_n), .data_in(bus),
		.data_out(dout), .data_oe_out(oe), .busy_out(busy),
		.error_out(err), .operand_transfer_request_out(req),
		.opcode_out(op), .opcode_valid_out(opv),
		.core_done_in(c_done), .core_exception_in(c_exc),
		.core_status_in(c_stat), .core_xfer_start_in(c_start),
		.core_xfer_count_in(c_cnt), .core_read_word_in(c_rd),
		.operand_word_out(wd), .operand_valid_out(wv),
		.fpu_operand_out(fpu), .exc_ptr_out(ep), .exc_ptr_valid_out(ev),
		.control_word_out(ctrl), .protected_mode_out(pm));
	// ----------------------------------------
	// Clock and checking helpers
	// ----------------------------------------
	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	task automatic check(input string what, input logic [95:0] got, exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask : check
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	task automatic tmo;
		n_errors++;
		$display("mismatch timeout");
		give_verdict();
	endtask : tmo
	// ----------------------------------------
	// Result monitor against the expected queues
	// ----------------------------------------
	always @(posedge clk_in)
	begin
		req_q <= req;
		if (oe === 1'b1)
			n_oe++;
		if (req_q === 1'b1 && req === 1'b0)
		begin
			seen.push_back(n_x - last_x);
			last_x = n_x;
		end
		if (opv === 1'b1)
		begin
			n_op++;
			check("opcode", op, eq_op.size() ? eq_op.pop_front() : 'x);
		end
		if (wv === 1'b1)
		begin
			n_w++;
			check("operand", wd, eq_w.size() ? eq_w.pop_front() : 'x);
		end
		if (ev === 1'b1)
		begin
			n_e++;
			check("excptr", ep, eq_e.size() ? eq_e.pop_front() : 'x);
		end
	end
	// ----------------------------------------
	// One instruction with its operand phase
	// ----------------------------------------
	task automatic instr(input int n, input bit rd, input bit exc,
		input bit ak);
		int k, b;
		logic [15:0] w;
		int exp_b[$];
		for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk_in);
		if (k == 400) tmo();
		w = {4'hF, 12'($urandom)};
		eq_op.push_back(w);
		host.io(AO, 1'b0, w, q);
		check("busy", busy, 1'b1);
		c_cnt <= 6'(n);
		c_start <= 1'b1;
		c_exc <= exc;
		@(posedge clk_in);
		c_start <= 1'b0;
		c_exc <= 1'b0;
		for (k = 0; k < 50 && n > 0 && req !== 1'b1; k++) @(posedge clk_in);
		if (n > 0 && k == 50) tmo();
		if (ak)
		begin
			host.ack(1'b1);
			repeat (4) @(posedge clk_in);
			check("ack drop", req, 1'b0);
			host.ack(1'b0);
		end
		seen.delete();
		last_x = n_x;
		k = n;
		b = (n > 5) ? 3 : n;
		while (k > 0)
		begin
			exp_b.push_back(b);
			k -= b;
			b = (k < 4) ? k : 4;
		end
		k = 0;
		while (k < n)
		begin
			for (b = 0; b < 50 && req !== 1'b1; b++) @(posedge clk_in);
			if (b == 50) tmo();
			w = 16'($urandom);
			n_x++;
			k++;
			if (rd)
			begin
				c_rd <= w;
				host.io(AD, 1'b1, 16'h0000, q);
				check("read word", q, w);
			end
			else
			begin
				eq_w.push_back(w);
				hist = {hist[79:0], w};
				host.io(AD, 1'b0, w, q);
			end
		end
		check("bursts", seen.size(), exp_b.size());
		foreach (exp_b[j])
			check("burst", seen.size() > j ? seen[j] : -1, exp_b[j]);
		c_done <= 1'b1;
		for (k = 0; k < 50 && busy !== 1'b0; k++) @(posedge clk_in);
		if (k == 50) tmo();
		check("req at idle", req, 1'b0);
		c_done <= 1'b0;
	endtask : instr
	task automatic stat(input logic [15:0] e, input string what);
		host.io(AO, 1'b1, 16'h0000, q);
		check(what, q, e);
	endtask : stat
	task automatic adm(input int a);
		host.io(AO, 1'b0, ADM[a], q);
		check("admin idle", busy, 1'b0);
	endtask : adm
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		resetn_in = 1'b0;
		strap = 1'b1;
		{c_done, c_exc, c_start, c_cnt, c_rd, hist} = '0;
		void'($urandom(32'hB05B));
		c_stat = 16'($urandom);
		repeat (12) @(posedge clk_in);
		check("reset outs", {busy, err, req, oe}, 4'hC);
		resetn_in <= 1'b1;
		host.io(AO, 1'b0, 16'hF123, q);
		repeat (20) @(posedge clk_in);
		check("warmup", {n_op, busy}, '0);
		$display("test reset done");
		instr(0, 0, 0, 0);
		instr(7, 0, 1, 0);
		check("fpu word", 96'(fpu), {12'h000, hist[83:0]});
		check("error", err, 1'b1);
		stat({c_stat[15:8], 1'b1, c_stat[6:0]}, "status es");
		adm(1);
		check("clex", err, 1'b0);
		c_exc <= 1'b1;
		@(posedge clk_in);
		c_exc <= 1'b0;
		repeat (5) @(posedge clk_in);
		check("idle exc", err, 1'b0);
		$display("test transfer done");
		instr(2, 1, 0, 0);
		instr(4, 0, 0, 1);
		adm(3);
		stat(`NPC_CTRL_RESET, "control");
		adm(2);
		stat({c_stat[15:8], 1'b0, c_stat[6:0]}, "status");
		adm(4);
		check("pm set", pm, 1'b1);
		adm(5);
		check("pm clr", pm, 1'b0);
		adm(0);
		check("init ctrl", ctrl, `NPC_CTRL_RESET);
		eq_e.push_back(16'h1E5C);
		host.io(`NPC_ADDR_EXCPTR, 1'b0, 16'h1E5C, q);
		$display("test admin done");
		i = n_op + n_w + n_e + n_oe;
		host.io(`NPC_ADDR_RESERVED, 1'b0, 16'hF0F0, q);
		host.cyc(1'b0, 1'b0, 2'h0, 1'b1, 1'b0, 16'hF0F1, q);
		host.cyc(1'b1, 1'b1, 2'h0, 1'b1, 1'b0, 16'hF0F2, q);
		host.cyc(1'b0, 1'b1, 2'h3, 1'b1, 1'b0, 16'hF0F3, q);
		host.cyc(1'b0, 1'b1, 2'h3, 1'b0, 1'b1, 16'h0000, q);
		host.cyc(1'b0, 1'b1, 2'h2, 1'b0, 1'b1, 16'h0000, q);
		host.cyc(1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 16'hF0F4, q);
		check("ignored", n_op + n_w + n_e + n_oe, i);
		check("ignored busy", busy, 1'b0);
		$display("test reserved done");
		strap <= 1'b0;
		resetn_in <= 1'b0;
		repeat (12) @(posedge clk_in);
		check("reset again", {busy, err, req, oe}, 4'hC);
		resetn_in <= 1'b1;
		repeat (60) @(posedge clk_in);
		instr(2, 0, 0, 0);
		$display("test divided clock done");
		give_verdict();
	end
endmodule : testbench
